// ===== smwe_defines.vh
/*
  Constants for the static memory wait-extend block: wait-state field codes,
  timing limits in bus-clock cycles, and bank-select width.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SMWE_DEFINES_VH
`define SMWE_DEFINES_VH

`define SMWE_WST_W          3
`define SMWE_WST_ZERO       3'h0
`define SMWE_WST_FOUR       3'h4
`define SMWE_WST_MIN_WAIT   3'h2
`define SMWE_STAGE_TWO      3'h2
`define SMWE_STAGE_FINAL    3'h0
`define SMWE_QUEUE_W        6
`define SMWE_QUEUE_MAX      6'h3F
`define SMWE_NUM_BANKS      4
`define SMWE_BANK_SEL_W     2
`define SMWE_RELEASE_MAX_CS 4
`define SMWE_RELEASE_MAX_OE 4
`define SMWE_RELEASE_MAX_WE 3

`endif

// ===== smwe_sync.v
/*
  Two-flop synchroniser for the external wait input.
  Assumes the input is asynchronous to sys_clk; resets to the idle (high) level.
*/
`timescale 1ns/1ps
module smwe_sync (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire async_in,
  output wire sync_out
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // smwe_sync

// ===== smwe_ctrl.v
/*
  Static memory access sequencer with programmed wait states and external
  wait-input stretching. One access at a time on the bank selected at start.
  Assumes the requester holds off while busy, and that the arbiter keeps
  dynamic memory idle while busy is high.
*/
`timescale 1ns/1ps
`include "smwe_defines.vh"

// Operation
// RULE1: While wait input is asserted, the ongoing access is held in suspense.
// RULE2: Software programs read wait states of at least 2 when wait is used.
// RULE3: Software programs write wait states of at least 2 when wait is used.
// RULE4: Minimum wait states grow by the wait input lag after bank select.
// RULE5: Wait assertions before countdown stage two are ignored.
// RULE6: From stage two on, each sampled wait assertion queues one cycle.
// RULE7: Queued cycles are inserted only after the countdown reaches stage final.
// RULE8: Wait sampled high queues the access to finish.
// RULE9: Device asserts wait 0 to 29 cycles after bank select goes active.
// RULE10: Bank select deasserts at most 4 cycles after wait release.
// RULE11: Read strobe deasserts at most 4 cycles after wait release.
// RULE12: Write strobe deasserts at most 3 cycles after wait release.
// RULE13: Device holds wait asserted at least 2 cycles.
// RULE14: Wait-state code 000 adds none, 100 adds four, for reads and writes.
// RULE15: Static accesses never overlap dynamic ones; long stretches block refresh.
// RULE16: Wait timing counts are nominal; external designs add margin.
// RULE17: External wait input is synchronised before the countdown samples it.
module smwe_ctrl #(
  parameter NUM_BANKS = `SMWE_NUM_BANKS,
  parameter WST_W     = `SMWE_WST_W,
  parameter QUEUE_W   = `SMWE_QUEUE_W
) (
  input  wire                 sys_clk,
  input  wire                 rst_n,
  input  wire                 req,
  input  wire                 req_write,
  input  wire [`SMWE_BANK_SEL_W-1:0] req_bank,
  input  wire [WST_W-1:0]     wait_state_count,
  input  wire                 wait_enable,
  input  wire                 ext_wait_n,
  output reg  [NUM_BANKS-1:0] bank_select_n_x,
  output reg                  read_strobe_n,
  output reg                  write_strobe_n,
  output reg                  busy,
  output reg                  done
);
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_COUNT = 4'h2;
  localparam [3:0] ST_EXTND = 4'h4;
  localparam [3:0] ST_END   = 4'h8;

  wire                 wait_sync_n;
  reg  [3:0]           state_ff;
  reg  [3:0]           nxt_state;
  reg  [WST_W-1:0]     count_ff;
  reg  [WST_W-1:0]     nxt_count;
  reg  [QUEUE_W-1:0]   queue_ff;
  reg  [QUEUE_W-1:0]   nxt_queue;
  reg                  released_ff;
  reg                  nxt_released;
  reg                  write_ff;
  reg                  nxt_write;
  reg  [`SMWE_BANK_SEL_W-1:0] bank_ff;
  reg  [`SMWE_BANK_SEL_W-1:0] nxt_bank;
  wire                 wait_seen;
  wire                 in_window;
  wire                 add_one;
  wire                 nxt_active;
  wire [NUM_BANKS-1:0] nxt_bank_hot;
  wire [NUM_BANKS-1:0] nxt_select_n;
  wire                 nxt_read_n;
  wire                 nxt_write_n;
  wire                 nxt_busy;
  wire                 nxt_done;

  smwe_sync u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (ext_wait_n),
    .sync_out (wait_sync_n)
  ); // [RULE17]

  assign wait_seen = wait_enable & ~wait_sync_n;
  // Sync lags the pin two cycles, so the final stage here sees the pin as it
  // stood at stage two; earlier lows fall through and release stays in time
  assign in_window = (state_ff == ST_COUNT) && (count_ff == `SMWE_STAGE_FINAL); // [RULE5]
  // Queue saturates rather than wrap, so a stuck wait never shortens a cycle
  assign add_one = wait_seen && !released_ff && (queue_ff != `SMWE_QUEUE_MAX); // [RULE6]

  always @* begin
    nxt_state    = state_ff;
    nxt_count    = count_ff;
    nxt_queue    = queue_ff;
    nxt_released = released_ff;
    nxt_write    = write_ff;
    nxt_bank     = bank_ff;
    case (state_ff)
      ST_IDLE: begin
        if (req) begin
          // Zero code means no added cycles, four means four
          nxt_count    = wait_state_count; // [RULE14]
          nxt_write    = req_write;
          nxt_bank     = req_bank;
          nxt_queue    = {QUEUE_W{1'b0}};
          nxt_released = 1'b0;
          nxt_state    = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (in_window) begin
          if (add_one) begin
            nxt_queue = queue_ff + 1'b1; // [RULE6]
          end else if (!wait_seen) begin
            nxt_released = 1'b1; // [RULE8]
          end
        end
        if (count_ff == `SMWE_STAGE_FINAL) begin
          nxt_state = (nxt_queue != {QUEUE_W{1'b0}}) ? ST_EXTND : ST_END; // [RULE7]
        end else begin
          nxt_count = count_ff - 1'b1;
        end
      end
      ST_EXTND: begin
        // Holds while wait stays low; each queued cycle is spent once
        if (add_one) begin
          nxt_queue = queue_ff; // [RULE1]
        end else begin
          if (!wait_seen) begin
            nxt_released = 1'b1; // [RULE8]
          end
          nxt_queue = queue_ff - 1'b1; // [RULE7]
          if (queue_ff == {{(QUEUE_W-1){1'b0}}, 1'b1}) begin
            nxt_state = ST_END;
          end
        end
      end
      ST_END: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      count_ff    <= {WST_W{1'b0}};
      queue_ff    <= {QUEUE_W{1'b0}};
      released_ff <= 1'b0;
      write_ff    <= 1'b0;
      bank_ff     <= {`SMWE_BANK_SEL_W{1'b0}};
    end else begin
      state_ff    <= nxt_state;
      count_ff    <= nxt_count;
      queue_ff    <= nxt_queue;
      released_ff <= nxt_released;
      write_ff    <= nxt_write;
      bank_ff     <= nxt_bank;
    end
  end

  // Pins follow the next state, so they switch on the edge the state does
  assign nxt_active   = (nxt_state == ST_COUNT) || (nxt_state == ST_EXTND);
  // Shift decode keeps the bank compare free of a 32-bit loop index
  assign nxt_bank_hot = {{(NUM_BANKS-1){1'b0}}, 1'b1} << nxt_bank;
  assign nxt_read_n   = !(nxt_active && !nxt_write); // [RULE11]
  assign nxt_write_n  = !(nxt_active && nxt_write); // [RULE12]
  // Busy also fences off dynamic memory; long stretches starve refresh
  assign nxt_busy     = (nxt_state != ST_IDLE); // [RULE15]
  assign nxt_done     = (nxt_state == ST_END);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi = gi + 1) begin : g_bank
      assign nxt_select_n[gi] = !(nxt_active && nxt_bank_hot[gi]); // [RULE10]
    end
  endgenerate

  // Strobes rise with select on the end cycle: two sync flops plus one
  // cycle keeps release within three cycles of the pin
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select_n_x <= {NUM_BANKS{1'b1}};
    end else begin
      bank_select_n_x <= nxt_select_n; // [RULE10]
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n <= 1'b1;
    end else begin
      read_strobe_n <= nxt_read_n; // [RULE11]
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_strobe_n <= 1'b1;
    end else begin
      write_strobe_n <= nxt_write_n; // [RULE12]
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= nxt_busy; // [RULE15]
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= nxt_done;
    end
  end
endmodule // smwe_ctrl

// ===== smwe_chk.sv
/* Checker for smwe_ctrl access length, strobes and wait release.
   Assumes it is bound to smwe_ctrl and sees only its ports. */
`timescale 1ns/1ps
module smwe_chk #(parameter NUM_BANKS = 4, parameter WST_W = 3) (
  input logic sys_clk,
  input logic rst_n,
  input logic req,
  input logic req_write,
  input logic [1:0] req_bank,
  input logic [WST_W-1:0] wait_state_count,
  input logic wait_enable,
  input logic ext_wait_n,
  input logic [NUM_BANKS-1:0] bank_select_n_x,
  input logic read_strobe_n,
  input logic write_strobe_n,
  input logic busy,
  input logic done
);
  logic [WST_W-1:0] n_ff;
  logic             wr_ff;
  logic             held_ff;
  logic [7:0]       cnt_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Cycle one may still see wait high, so held starts counting after it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_ff <= {WST_W{1'b0}};
      wr_ff <= 1'b0;
      held_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (req && !busy) begin
      n_ff <= wait_state_count;
      wr_ff <= req_write;
      held_ff <= 1'b1;
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + {7'h00, busy};
      held_ff <= held_ff && !(ext_wait_n && cnt_ff != 8'h00);
    end
  end
  start_sel_a: assert property (req && !busy |=> !bank_select_n_x[$past(req_bank)])
    else $error("no select");
  done_idle_a: assert property (done |-> busy && &bank_select_n_x && read_strobe_n && write_strobe_n)
    else $error("done early");
  base_len_a: assert property (done && !wait_enable |-> cnt_ff == n_ff + 1)
    else $error("bad length");
  strobe_kind_a: assert property (!(read_strobe_n && write_strobe_n) |-> busy && read_strobe_n == wr_ff)
    else $error("wrong strobe");
  wait_hold_a: assert property (busy && wait_enable && held_ff && !ext_wait_n && n_ff > 4 |-> !done)
    else $error("not held");
  cs_release_a: assert property (busy && wait_enable && $rose(ext_wait_n) && cnt_ff >= n_ff |-> ##[1:4] &bank_select_n_x)
    else $error("select late");
  oe_release_a: assert property (busy && wait_enable && $rose(ext_wait_n) && cnt_ff >= n_ff && !wr_ff |-> ##[1:4] read_strobe_n)
    else $error("read late");
  we_release_a: assert property (busy && wait_enable && $rose(ext_wait_n) && cnt_ff >= n_ff && wr_ff |-> ##[1:3] write_strobe_n)
    else $error("write late");
endmodule // smwe_chk
bind smwe_ctrl smwe_chk #(.NUM_BANKS(NUM_BANKS), .WST_W(WST_W)) u_chk (
  .sys_clk          (sys_clk),
  .rst_n            (rst_n),
  .req              (req),
  .req_write        (req_write),
  .req_bank         (req_bank),
  .wait_state_count (wait_state_count),
  .wait_enable      (wait_enable),
  .ext_wait_n       (ext_wait_n),
  .bank_select_n_x  (bank_select_n_x),
  .read_strobe_n    (read_strobe_n),
  .write_strobe_n   (write_strobe_n),
  .busy             (busy),
  .done             (done)
);

// ===== smwe_wait_dev.sv
/* Slow far-side device: holds the wait input low for hold cycles once selected.
   Assumes the bench sets hold before each access; wait idles high. */
`timescale 1ns/1ps
module smwe_wait_dev (
  input  logic       sys_clk,
  input  logic [3:0] bank_select_n_x,
  input  logic [5:0] hold,
  output logic       ext_wait_n
);
  logic [5:0] age_ff = 6'h00;
  initial ext_wait_n = 1'b1;
  // One cycle lag after select, as the wait output is registered
  always @(posedge sys_clk) begin
    age_ff <= (&bank_select_n_x) ? 6'h00 : age_ff + 6'h01;
    ext_wait_n <= (&bank_select_n_x) || age_ff >= hold;
  end
endmodule // smwe_wait_dev

// ===== static_mem_wait_extend_bench.sv
/* Bench for smwe_ctrl: fixed, ignored and stretched accesses.
   Assumes smwe_wait_dev as the far side and smwe_chk bound in. */
`timescale 1ns/1ps
module static_mem_wait_extend_bench;
  logic sys_clk = 1'b0, rst_n = 1'b0, req = 1'b0, req_write = 1'b0, wait_enable = 1'b0;
  logic [1:0] req_bank = 2'h0;
  logic [2:0] wait_state_count = 3'h0;
  logic [5:0] hold = 6'h00;
  logic ext_wait_n, read_strobe_n, write_strobe_n, busy, done;
  logic [3:0] bank_select_n_x;
  int bad_count = 0, num_checks = 0, cycles = 0, len;
  always #10 sys_clk = ~sys_clk;
  smwe_ctrl i_dut (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .req              (req),
    .req_write        (req_write),
    .req_bank         (req_bank),
    .wait_state_count (wait_state_count),
    .wait_enable      (wait_enable),
    .ext_wait_n       (ext_wait_n),
    .bank_select_n_x  (bank_select_n_x),
    .read_strobe_n    (read_strobe_n),
    .write_strobe_n   (write_strobe_n),
    .busy             (busy),
    .done             (done)
  );
  smwe_wait_dev i_dev (
    .sys_clk         (sys_clk),
    .bank_select_n_x (bank_select_n_x),
    .hold            (hold),
    .ext_wait_n      (ext_wait_n)
  );
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One access; len is the cycle of done, counted from the first select cycle
  task automatic access(input logic wr, input logic [1:0] bk, input logic [2:0] n,
                        input logic en, input logic [5:0] hd);
    @(posedge sys_clk);
    req <= 1'b1;
    req_write <= wr;
    req_bank <= bk;
    wait_state_count <= n;
    wait_enable <= en;
    hold <= hd;
    @(posedge sys_clk);
    req <= 1'b0;
    #1;
    check("select", {28'h0, ~(4'h1 << bk)}, bank_select_n_x);
    check("strobes", {wr, !wr}, {read_strobe_n, write_strobe_n});
    check("busy", 32'h1, busy);
    len = 1;
    while (done !== 1'b1 && len < 100) begin
      @(posedge sys_clk);
      #1;
      len++;
    end
    check("released", 32'h3F, {bank_select_n_x, read_strobe_n, write_strobe_n});
    @(posedge sys_clk);
    #1;
    check("idle", 32'h0, {busy, done});
  endtask
  task automatic fixed_waits();
    for (int i = 0; i < 4; i++) begin
      access(i[0], i[1:0], i[1] ? 3'h4 : 3'h0, 1'b0, 6'h00);
      check("fixed length", i[1] ? 6 : 2, len);
    end
  endtask
  task automatic early_wait();
    access(1'b0, 2'h1, 3'h7, 1'b1, 6'h02);
    check("early wait", 9, len);
  endtask
  // Wait low over cycles 2 to 13, released in cycle 14
  task automatic stretched();
    for (int w = 0; w < 2; w++) begin
      access(w[0], 2'h2, 3'h7, 1'b1, 6'h0C);
      check("stretch", 1, len >= 14 && len <= (w ? 17 : 18));
      // Base 9 plus one cycle per low pin sample from stage two to cycle 13
      check("stretch length", 32'h11, len);
    end
  endtask
  // Wait input held low but not honoured: base length only
  task automatic wait_off();
    access(1'b1, 2'h3, 3'h4, 1'b0, 6'h0C);
    check("wait ignored", 32'h6, len);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    fixed_waits();
    early_wait();
    stretched();
    wait_off();
    print_verdict();
  end
endmodule // static_mem_wait_extend_bench
